// ### hdl/sachs_pkg.sv
// Package: constants for the conversion-control and readout block
// Assumes a 20 MHz core clock; no registers reachable by software
package sachs_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CONV_TIME_NS = 1400;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACQ_TIME_NS = 160;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_SETUP_NS = 20;
    localparam int DATA_SETUP_CYCLES = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESULT_W = 12;
    localparam int CNT_W = 6;
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
    localparam logic [RESULT_W-1:0] SIGN_FLIP = 12'h800;
    typedef enum logic [1:0] {
        SACHS_IDLE = 2'b00,
        SACHS_CONV = 2'b01,
        SACHS_LOAD = 2'b11
    } sachs_state_t;
endpackage : sachs_pkg

// ### hdl/sachs_edge.sv
// Falling-edge detector for an active-low synchronous strobe
// Assumes the input is synchronous to the clock
`timescale 1ns/10ps
`default_nettype none
module sachs_edge
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Strobe
    input wire logic sig_n,
    output logic fall
);
    logic prev_r;
    logic prev_nxt;

    always_comb
    begin
        prev_nxt = sig_n;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prev_r <= 1'b1;
        else
            prev_r <= prev_nxt;
    end

    assign fall = prev_r & ~sig_n;
endmodule : sachs_edge
`default_nettype wire

// ### hdl/sachs_top.sv
// Conversion control and parallel result readout of a 12-bit sampling converter
// Assumes all pins synchronous to CORE_CLK; the comparator result arrives as a word
`timescale 1ns/10ps
`default_nettype none
module sachs_top
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Host control
    input wire logic CS_N,
    input wire logic CONV_START_N,
    input wire logic RD_N,
    input wire logic POWER_DOWN_N,
    input wire logic BIPOLAR,
    // Sampled analog word, offset binary
    input wire logic [sachs_pkg::RESULT_W-1:0] SAMPLE_IN,
    // Outputs
    output logic BUSY_N,
    output logic POWERED_DOWN,
    output logic [sachs_pkg::RESULT_W-1:0] RESULT_BITS,
    output logic RESULT_OE_N
);
    import sachs_pkg::*;

    sachs_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [RESULT_W-1:0] hold_r, hold_nxt;
    logic [RESULT_W-1:0] out_r, out_nxt;
    logic busy_n_r, busy_n_nxt;
    logic start_fall;
    logic start_ok;

    sachs_edge u_start_edge
    (
        .clk(CORE_CLK),
        .rst(RST),
        .sig_n(CONV_START_N),
        .fall(start_fall)
    );

    // Power-down blocks new starts but lets a running conversion finish
    assign start_ok = start_fall & ~CS_N & POWER_DOWN_N;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        hold_nxt = hold_r;
        out_nxt = out_r;
        busy_n_nxt = busy_n_r;
        case (state_r)
            SACHS_IDLE:
            begin
                busy_n_nxt = 1'b1;
                if (start_ok)
                begin
                    hold_nxt = SAMPLE_IN;
                    // Setup margin counts inside the busy window, so busy totals the conversion
                    cnt_nxt = CNT_W'(CONV_CYCLES - DATA_SETUP_CYCLES - 1);
                    busy_n_nxt = 1'b0;
                    state_nxt = SACHS_CONV;
                end
            end
            SACHS_CONV:
            begin
                // No start test here: a running conversion cannot restart
                if (cnt_r == '0)
                begin
                    out_nxt = BIPOLAR ? (hold_r ^ SIGN_FLIP) : hold_r;
                    cnt_nxt = CNT_W'(DATA_SETUP_CYCLES);
                    state_nxt = SACHS_LOAD;
                end
                else
                    cnt_nxt = cnt_r - CNT_W'(1);
            end
            SACHS_LOAD:
            begin
                // Data latched, busy held low for the setup margin
                if (cnt_r == CNT_W'(1))
                begin
                    busy_n_nxt = 1'b1;
                    state_nxt = SACHS_IDLE;
                end
                cnt_nxt = cnt_r - CNT_W'(1);
            end
            default:
            begin
                state_nxt = SACHS_IDLE;
                busy_n_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge RST)
    begin
        if (RST)
        begin
            state_r <= SACHS_IDLE;
            cnt_r <= '0;
            hold_r <= RESULT_RST;
            out_r <= RESULT_RST;
            busy_n_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            out_r <= out_nxt;
            busy_n_r <= busy_n_nxt;
        end
    end

    assign BUSY_N = busy_n_r;
    assign RESULT_BITS = out_r;
    // Enable is active low; enables are combinational for fast bus release
    assign RESULT_OE_N = RD_N | CS_N;
    assign POWERED_DOWN = ~POWER_DOWN_N;

    // Busy window of 28 samples; the repeats are split because the tools unroll them
    sequence s_busy_held;
        !BUSY_N [*8] ##1 !BUSY_N [*8] ##1 !BUSY_N [*8] ##1 !BUSY_N [*4];
    endsequence : s_busy_held

    sequence s_busy_release;
        BUSY_N && state_r == SACHS_IDLE;
    endsequence : s_busy_release

    sequence s_start_taken;
        start_ok && state_r == SACHS_IDLE;
    endsequence : s_start_taken

    // Checks on the host-visible handshake and on internal state and counter; counts follow the package timing
    a_busy_start: assert property (@(posedge CORE_CLK) disable iff (RST)
        start_ok && state_r == SACHS_IDLE |=> !BUSY_N == 1'b1)
        else $error("busy not asserted after start");

    a_hold_capture: assert property (@(posedge CORE_CLK) disable iff (RST)
        s_start_taken |=> hold_r == $past(SAMPLE_IN))
        else $error("input word not captured at start");

    a_busy_len: assert property (@(posedge CORE_CLK) disable iff (RST)
        $fell(BUSY_N) |-> s_busy_held ##1 s_busy_release)
        else $error("busy window has wrong length");

    a_busy_state: assert property (@(posedge CORE_CLK) disable iff (RST)
        BUSY_N == (state_r == SACHS_IDLE))
        else $error("busy does not match conversion state");

    a_busy_end: assert property (@(posedge CORE_CLK) disable iff (RST)
        $fell(BUSY_N) |-> ##[1:33] BUSY_N)
        else $error("sample cycle too long");

    a_cnt_range: assert property (@(posedge CORE_CLK) disable iff (RST)
        state_r == SACHS_CONV |-> cnt_r <= CNT_W'(CONV_CYCLES - DATA_SETUP_CYCLES - 1))
        else $error("conversion counter out of range");

    a_data_setup: assert property (@(posedge CORE_CLK) disable iff (RST)
        $rose(BUSY_N) |-> $stable(RESULT_BITS) && state_r == SACHS_IDLE
        && $past(state_r) == SACHS_LOAD)
        else $error("data not stable before busy rises");

    a_load_len: assert property (@(posedge CORE_CLK) disable iff (RST)
        state_r == SACHS_LOAD |=> state_r == SACHS_IDLE)
        else $error("setup margin too long");

    a_result_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        !(state_r == SACHS_LOAD && $past(state_r) == SACHS_CONV) |-> $stable(RESULT_BITS))
        else $error("result changed outside conversion end");

    a_no_restart: assert property (@(posedge CORE_CLK) disable iff (RST)
        !BUSY_N && start_fall |=> (state_r != SACHS_IDLE || BUSY_N) && $stable(hold_r)
        && cnt_r != CNT_W'(CONV_CYCLES - DATA_SETUP_CYCLES - 1))
        else $error("conversion restarted");

    a_select_gate: assert property (@(posedge CORE_CLK) disable iff (RST)
        CS_N && state_r == SACHS_IDLE |=> BUSY_N)
        else $error("start taken without select");

    a_cs_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        start_fall && CS_N |=> $stable(hold_r))
        else $error("word captured without select");

    a_idle_stay: assert property (@(posedge CORE_CLK) disable iff (RST)
        state_r == SACHS_IDLE && !start_ok |=> state_r == SACHS_IDLE)
        else $error("conversion began without a valid start");

    a_oe_float: assert property (@(posedge CORE_CLK) disable iff (RST)
        CS_N |-> RESULT_OE_N)
        else $error("drivers on while deselected");

    a_oe_read: assert property (@(posedge CORE_CLK) disable iff (RST)
        !CS_N && !RD_N |-> !RESULT_OE_N)
        else $error("drivers off during read");

    a_pd_block: assert property (@(posedge CORE_CLK) disable iff (RST)
        !POWER_DOWN_N && state_r == SACHS_IDLE |=> BUSY_N)
        else $error("start taken in power-down");

    a_pd_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
        start_fall && !POWER_DOWN_N |=> $stable(hold_r))
        else $error("word captured in power-down");

    a_pd_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
        POWERED_DOWN == !POWER_DOWN_N)
        else $error("power-down flag wrong");

    a_bipolar: assert property (@(posedge CORE_CLK) disable iff (RST)
        state_r == SACHS_CONV && cnt_r == '0 |=>
        RESULT_BITS == ($past(BIPOLAR) ? ($past(hold_r) ^ SIGN_FLIP) : $past(hold_r)))
        else $error("wrong result coding");
endmodule : sachs_top
`default_nettype wire

// ### test/sachs_host.sv
// Host model: drives device select and conversion start
// Assumes the bench pulses req for one cycle per start
`timescale 1ns/10ps
`default_nettype none
module sachs_host
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench control
    input wire logic req,
    input wire logic desel,
    // Device pins
    output logic cs_n,
    output logic conv_start_n
);
    logic [1:0] cnt_r;
    assign cs_n = desel;
    // Low 100 ns only, so it rises before the first bit decision
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_r <= 2'h0;
        else
            cnt_r <= req ? 2'h2 : cnt_r - {1'b0, cnt_r != 2'h0};
    end
    assign conv_start_n = (cnt_r == 2'h0);
endmodule : sachs_host
`default_nettype wire

// ### test/tb_sampling_adc_conversion_handshake.sv
// Self-checking bench for the conversion handshake
// Assumes sachs_host stands for the host on select and start
`timescale 1ns/10ps
`default_nettype none
module tb_sampling_adc_conversion_handshake;
    import sachs_pkg::*;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, desel = 1'b0, rd_n = 1'b1, pd_n = 1'b1;
    logic bip = 1'b0, cs_n, st_n, busy_n, pd, oe_n;
    logic [RESULT_W-1:0] smp = 12'h000, res;
    int err_count = 0, checked = 0;
    always #25 clk = ~clk;
    sachs_host host_u (.clk(clk), .rst(rst), .req(req), .desel(desel), .cs_n(cs_n),
        .conv_start_n(st_n));
    sachs_top dut_u (.CORE_CLK(clk), .RST(rst), .CS_N(cs_n), .CONV_START_N(st_n),
        .RD_N(rd_n), .POWER_DOWN_N(pd_n), .BIPOLAR(bip), .SAMPLE_IN(smp),
        .BUSY_N(busy_n), .POWERED_DOWN(pd), .RESULT_BITS(res), .RESULT_OE_N(oe_n));
    task automatic chk(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse();
        @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
    endtask : pulse
    // A second start mid-run must leave length and captured word alone
    task automatic conv(input logic [11:0] s, input logic b, input logic [11:0] e,
        input logic twice);
        int n;
        logic [11:0] last;
        n = 0;
        smp <= s;
        bip <= b;
        pulse();
        while (busy_n !== 1'b0 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (busy_n === 1'b0 && n < 40)
        begin
            last = res;
            n++;
            @(posedge clk);
            req <= twice && n == 6;
            if (twice && n == 6)
                smp <= ~s;
            @(negedge clk);
        end
        chk(12'(n), 12'(CONV_CYCLES));
        chk(last, e);
        @(posedge clk);
        rd_n <= 1'b0;
        @(negedge clk);
        chk({11'h000, oe_n}, 12'h000);
        @(posedge clk);
        rd_n <= 1'b1;
        // Keeps start-to-start spacing above the minimum throughput time
        repeat (ACQ_CYCLES) @(posedge clk);
        $display("conv %h done", s);
    endtask : conv
    task automatic blocked(input logic sel_off);
        @(posedge clk);
        desel <= sel_off;
        pd_n <= sel_off;
        rd_n <= 1'b0;
        pulse();
        repeat (8) @(negedge clk);
        chk({11'h000, busy_n}, 12'h001);
        chk({11'h000, oe_n}, {11'h000, sel_off});
        chk({11'h000, pd}, {11'h000, ~sel_off});
        @(posedge clk);
        desel <= 1'b0;
        pd_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (7) @(posedge clk);
        $display("blocked start done");
    endtask : blocked
    task automatic results();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        conv(12'h800, 1'b0, 12'h800, 1'b0);
        conv(12'h800, 1'b1, 12'h000, 1'b0);
        conv(12'h7FF, 1'b1, 12'hFFF, 1'b1);
        blocked(1'b1);
        blocked(1'b0);
        conv(12'hA5C, 1'b0, 12'hA5C, 1'b0);
        results();
    end
    initial
    begin
        #100000;
        err_count++;
        results();
    end
endmodule : tb_sampling_adc_conversion_handshake
`default_nettype wire
